/* capture_consts.vh */
// Constants for the input capture channel: offsets, field positions, codes and reset values.
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH

// Register byte addresses on the AXI4-Lite bus.
`define ADDR_CONTROL 4'h0
`define ADDR_CAPTURE 4'h4
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_ENABLE 4'hC
`define ADDR_WIDTH 4

// Control register field positions.
`define BIT_IDLE_HALT 13
`define TSEL_HI 12
`define TSEL_LO 10
`define CPI_HI 6
`define CPI_LO 5
`define BIT_OVERFLOW 4
`define BIT_NOT_EMPTY 3
`define MODE_HI 2
`define MODE_LO 0
`define CONTROL_WRITE_MASK 16'h3C67
`define CONTROL_RESET 16'h0000

// Capture mode codes.
`define MODE_OFF 3'h0
`define MODE_BOTH 3'h1
`define MODE_FALL 3'h2
`define MODE_RISE 3'h3
`define MODE_RISE4 3'h4
`define MODE_RISE16 3'h5
`define MODE_UNUSED 3'h6
`define MODE_WAKE 3'h7

// Time base select codes.
`define TSEL_T3 3'h0
`define TSEL_T2 3'h1
`define TSEL_T4 3'h2
`define TSEL_T5 3'h3
`define TSEL_T1 3'h4
`define TSEL_PCLK 3'h7

// Buffer depth and interrupt status bits.
`define BUF_DEPTH 4
`define BUF_PTR_W 2
`define IRQ_CAPTURE 0
`define IRQ_OVERFLOW 1
`define IRQ_WAKE 2
`define IRQ_BITS 3

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* capture_edge_detect.v */
// Edge detector for the capture input, with a two-flop synchroniser.
`timescale 1ns/10ps
`default_nettype none

module capture_edge_detect (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Raw pin and detected edges.
	input wire pin_in,
	output reg rise_q,
	output reg fall_q
);

	reg meta_q;
	reg sync_q;
	reg last_q;

	// The first flop feeds only the second; edges are found after the second.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
			rise_q <= sync_q & ~last_q;
			fall_q <= ~sync_q & last_q;
		end
	end

endmodule
`default_nettype wire

/* capture_source_model.sv */
// Far-side model: pulse trains on the capture pin and free-running time bases.
`timescale 1ns/10ps
`default_nettype none
module capture_source_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Pin and time bases.
	output var logic pin,
	output wire logic [15:0] peripheral_clock,
	output wire logic [15:0] timer1_clock,
	output wire logic [15:0] timer2_clock,
	output wire logic [15:0] timer3_clock,
	output wire logic [15:0] timer4_clock,
	output wire logic [15:0] timer5_clock
);
	logic [15:0] cnt_q;
	initial pin = 1'b0;
	// One shared count; each base adds its own offset, whose top nibble names the base.
	// The extra half nibble lets the bench subtract the live count and still read the name.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 16'h0000;
		else cnt_q <= cnt_q + 16'h0001;
	end
	// Every base moves only on clk, since only synchronous clocking is offered.
	assign peripheral_clock = cnt_q + 16'hF800;
	assign timer1_clock = cnt_q + 16'h1800;
	assign timer2_clock = cnt_q + 16'h2800;
	assign timer3_clock = cnt_q + 16'h3800;
	assign timer4_clock = cnt_q + 16'h4800;
	assign timer5_clock = cnt_q + 16'h5800;
	// Pulses of twelve cycles, six high; the tail covers the pin-to-buffer latency.
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (6) @(posedge clk);
			pin <= 1'b0;
			repeat (5) @(posedge clk);
		end
		repeat (10) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* input_capture_channel.v */
// Input capture channel with an AXI4-Lite register slave and a level interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "capture_consts.vh"

// Behaviour
// - Idle-halt bit one stops captures during CPU Idle; zero keeps running.
// - Captures-per-interrupt 00..11 interrupts every first, second, third, fourth capture.
// - Captures-per-interrupt ignored in both-edges and sleep/idle pin modes.
// - Overflow flag set and cleared by hardware only, read-only, resets zero.
// - Mode 110 is unused and behaves as disabled.
// - Mode 101 captures every sixteenth rising edge through the prescaler.
// - Mode 100 captures every fourth rising edge through the prescaler.
// - Mode 010 captures every falling edge.
// - Mode 001 captures every rising and every falling edge.
// - Mode 000 turns the channel off; no captures.
// - Unimplemented control bits, including 9-7 and 15-14, read zero, ignore writes.
// - Timer 1 time base supports synchronous clocking only.
module input_capture_channel (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Capture pin and processor power state.
	input wire capture_channel,
	input wire cpu_idle,
	input wire cpu_sleep,
	// Time base values, already synchronous to clk.
	input wire [15:0] peripheral_clock,
	input wire [15:0] timer1_clock,
	input wire [15:0] timer2_clock,
	input wire [15:0] timer3_clock,
	input wire [15:0] timer4_clock,
	input wire [15:0] timer5_clock,
	// AXI4-Lite write channels.
	input wire [`ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read channels.
	input wire [`ADDR_WIDTH-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Interrupt.
	output reg irq_q
);

	wire rise;
	wire fall;
	reg [15:0] control_q;
	reg [15:0] buf_mem_q [0:`BUF_DEPTH-1];
	reg [`BUF_PTR_W-1:0] wr_ptr_q;
	reg [`BUF_PTR_W-1:0] rd_ptr_q;
	reg [`BUF_PTR_W:0] count_q;
	reg overflow_q;
	reg [3:0] prescale_q;
	reg [1:0] cpi_count_q;
	reg [`IRQ_BITS-1:0] irq_status_q;
	reg [`IRQ_BITS-1:0] irq_enable_q;
	reg [`ADDR_WIDTH-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg aw_have_q;
	reg w_have_q;
	reg [2:0] mode;
	reg [15:0] timebase;
	reg capture_fire;
	reg cpi_event;
	reg wake_event;
	reg buf_pop;
	reg halted;
	reg [31:0] rd_value;
	reg rd_ok;
	reg wr_do;
	reg [`IRQ_BITS-1:0] irq_set;
	reg [`IRQ_BITS-1:0] irq_clear;

	// Synchronised pin edges; the pin is asynchronous to clk.
	capture_edge_detect edge_detect (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(capture_channel),
		.rise_q(rise),
		.fall_q(fall)
	);

	// Applies the byte strobes to the two low lanes of a 16-bit value.
	function [15:0] merge_lanes;
		input [15:0] old_value;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge_lanes = old_value;
			if (strb[0])
				merge_lanes[7:0] = data[7:0];
			if (strb[1])
				merge_lanes[15:8] = data[15:8];
		end
	endfunction

	// Time base mux; reserved codes read zero so captures stamp nothing useful.
	always @* begin
		mode = control_q[`MODE_HI:`MODE_LO];
		case (control_q[`TSEL_HI:`TSEL_LO])
			`TSEL_PCLK: timebase = peripheral_clock;
			`TSEL_T5: timebase = timer5_clock;
			`TSEL_T4: timebase = timer4_clock;
			`TSEL_T2: timebase = timer2_clock;
			`TSEL_T3: timebase = timer3_clock;
			`TSEL_T1: timebase = timer1_clock;
			default: timebase = 16'h0000;
		endcase
	end

	// Capture decision per mode; idle halt blocks every capture mode.
	always @* begin
		halted = control_q[`BIT_IDLE_HALT] & cpu_idle;
		capture_fire = 1'b0;
		wake_event = 1'b0;
		case (mode)
			`MODE_BOTH: capture_fire = rise | fall;
			`MODE_FALL: capture_fire = fall;
			`MODE_RISE: capture_fire = rise;
			`MODE_RISE4: capture_fire = rise && (prescale_q[1:0] == 2'h3);
			`MODE_RISE16: capture_fire = rise && (prescale_q == 4'hF);
			`MODE_WAKE: wake_event = rise & (cpu_sleep | cpu_idle);
			default: capture_fire = 1'b0;
		endcase
		if (halted)
			capture_fire = 1'b0;
		// Both-edge mode interrupts on every capture, whatever the count field says.
		if (mode == `MODE_BOTH)
			cpi_event = capture_fire;
		else
			cpi_event = capture_fire && (cpi_count_q == control_q[`CPI_HI:`CPI_LO]);
	end

	// Edge prescaler and captures-per-interrupt counter.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_q <= 4'h0;
			cpi_count_q <= 2'h0;
		end else begin
			if (mode != `MODE_RISE4 && mode != `MODE_RISE16)
				prescale_q <= 4'h0;
			else if (rise && !halted)
				prescale_q <= prescale_q + 4'h1;
			if (mode == `MODE_OFF || mode == `MODE_UNUSED || mode == `MODE_WAKE || mode == `MODE_BOTH)
				cpi_count_q <= 2'h0;
			else if (cpi_event)
				cpi_count_q <= 2'h0;
			else if (capture_fire)
				cpi_count_q <= cpi_count_q + 2'h1;
		end
	end

	// Capture buffer. A full buffer drops the new value and flags overflow,
	// which clears by hardware once software drains the buffer empty.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= {`BUF_PTR_W{1'b0}};
			rd_ptr_q <= {`BUF_PTR_W{1'b0}};
			count_q <= {(`BUF_PTR_W+1){1'b0}};
			overflow_q <= 1'b0;
		end else if (mode == `MODE_OFF) begin
			// Turning the channel off flushes the buffer.
			wr_ptr_q <= {`BUF_PTR_W{1'b0}};
			rd_ptr_q <= {`BUF_PTR_W{1'b0}};
			count_q <= {(`BUF_PTR_W+1){1'b0}};
			overflow_q <= 1'b0;
		end else begin
			if (capture_fire && count_q == `BUF_DEPTH)
				overflow_q <= 1'b1;
			else if (buf_pop && count_q == 3'h1)
				overflow_q <= 1'b0;
			if (capture_fire && count_q != `BUF_DEPTH) begin
				buf_mem_q[wr_ptr_q] <= timebase;
				wr_ptr_q <= wr_ptr_q + 2'h1;
			end
			if (buf_pop)
				rd_ptr_q <= rd_ptr_q + 2'h1;
			if ((capture_fire && count_q != `BUF_DEPTH) && !buf_pop)
				count_q <= count_q + 3'h1;
			else if (buf_pop && !(capture_fire && count_q != `BUF_DEPTH))
				count_q <= count_q - 3'h1;
		end
	end

	// Read mux; reserved control bits and unmapped offsets read zero.
	always @* begin
		rd_value = 32'h0000_0000;
		rd_ok = 1'b1;
		buf_pop = 1'b0;
		case (s_axi_araddr)
			`ADDR_CONTROL: begin
				rd_value[15:0] = control_q & `CONTROL_WRITE_MASK;
				rd_value[`BIT_OVERFLOW] = overflow_q;
				rd_value[`BIT_NOT_EMPTY] = (count_q != 3'h0);
			end
			`ADDR_CAPTURE: begin
				rd_value[15:0] = (count_q != 3'h0) ? buf_mem_q[rd_ptr_q] : 16'h0000;
				buf_pop = s_axi_arvalid && !s_axi_rvalid && (count_q != 3'h0);
			end
			`ADDR_IRQ_STATUS: rd_value[`IRQ_BITS-1:0] = irq_status_q;
			`ADDR_IRQ_ENABLE: rd_value[`IRQ_BITS-1:0] = irq_enable_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: one read at a time, answered in the cycle after address.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready)
					s_axi_rvalid <= 1'b0;
			end else if (s_axi_arvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_value;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// Write address and data are taken in either order; response follows both.
	always @* begin
		wr_do = aw_have_q && w_have_q && !s_axi_bvalid;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= {`ADDR_WIDTH{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == `ADDR_CAPTURE || awaddr_q > `ADDR_IRQ_ENABLE) ?
					`RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Interrupt events: count-qualified capture, overflow onset, wake edge.
	always @* begin
		irq_set = {`IRQ_BITS{1'b0}};
		irq_set[`IRQ_CAPTURE] = cpi_event;
		irq_set[`IRQ_OVERFLOW] = capture_fire && count_q == `BUF_DEPTH && !overflow_q;
		irq_set[`IRQ_WAKE] = wake_event;
		irq_clear = {`IRQ_BITS{1'b0}};
		if (wr_do && awaddr_q == `ADDR_IRQ_STATUS && wstrb_q[0])
			irq_clear = wdata_q[`IRQ_BITS-1:0];
	end

	// Register writes; a set in the clearing cycle wins over the clear.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_q <= `CONTROL_RESET;
			irq_status_q <= {`IRQ_BITS{1'b0}};
			irq_enable_q <= {`IRQ_BITS{1'b0}};
			irq_q <= 1'b0;
		end else begin
			if (wr_do && awaddr_q == `ADDR_CONTROL)
				control_q <= merge_lanes(control_q, wdata_q, wstrb_q) & `CONTROL_WRITE_MASK;
			if (wr_do && awaddr_q == `ADDR_IRQ_ENABLE && wstrb_q[0])
				irq_enable_q <= wdata_q[`IRQ_BITS-1:0];
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_set;
			irq_q <= |(((irq_status_q & ~irq_clear) | irq_set) & irq_enable_q);
		end
	end

endmodule
`default_nettype wire

/* input_capture_channel_checker.sv */
// Bus and register-view checker for the input capture channel.
`timescale 1ns/10ps
`default_nettype none
module input_capture_channel_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Write channels.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [3:0] rd_addr_q;
	logic [3:0] wr_addr_q;
	wire [3:0] rd_addr;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Remember the taken addresses, since the answers outlive the requests.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr_q <= 4'h0;
			wr_addr_q <= 4'h0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
			if (s_axi_awvalid && s_axi_awready) wr_addr_q <= s_axi_awaddr;
		end
	end
	// The answer edge still carries the request address.
	assign rd_addr = s_axi_arready ? s_axi_araddr : rd_addr_q;
	property p_read_answer;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered in one cycle");
	property p_rvalid_drop;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rvalid_drop: assert property (p_rvalid_drop) else $error("read data kept after handshake");
	property p_write_answer;
		s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_wready && !s_axi_bvalid
			|=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered in time");
	property p_bvalid_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bvalid_drop: assert property (p_bvalid_drop) else $error("write response kept after handshake");
	property p_bresp_code;
		s_axi_bvalid |-> s_axi_bresp == ((wr_addr_q == 4'h4 || wr_addr_q > 4'hC) ? 2'h2 : 2'h0);
	endproperty
	a_bresp_code: assert property (p_bresp_code) else $error("wrong write response code");
	property p_ctrl_unused;
		s_axi_rvalid && rd_addr == 4'h0 |-> s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[9:7] == 3'h0;
	endproperty
	a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused control bits not zero");
	property p_ovf_not_empty;
		s_axi_rvalid && rd_addr == 4'h0 && s_axi_rdata[4] |-> s_axi_rdata[3];
	endproperty
	a_ovf_not_empty: assert property (p_ovf_not_empty) else $error("overflow with empty buffer");
	property p_status_bits;
		s_axi_rvalid && rd_addr == 4'h8 |-> s_axi_rdata[31:3] == 29'h0;
	endproperty
	a_status_bits: assert property (p_status_bits) else $error("status has stray bits");
endmodule
bind input_capture_channel input_capture_channel_checker u_chk (.clk(clk), .rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* tb_input_capture_channel.sv */
// Self-checking bench for the input capture channel.
`timescale 1ns/10ps
`default_nettype none
module tb_input_capture_channel;
	logic clk, rst_n, pin, idle, sleep, irq;
	logic [15:0] pc, t1, t2, t3, t4, t5, v0, v1, dt;
	logic [3:0] awaddr, araddr;
	logic [3:0] wstrb, st;
	logic [31:0] wdata, rdata, r;
	logic [1:0] bresp, rresp, resp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int miscompares, n_tests, cnt, i;
	// Per mode: pulses given, captures expected, cycles between the first two stamps.
	int np[7] = '{2, 2, 2, 2, 8, 32, 2};
	int nc[7] = '{0, 4, 2, 2, 2, 2, 0};
	int sp[7] = '{0, 6, 12, 12, 48, 192, 0};
	logic [2:0] tc[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h6};
	logic [3:0] tn[8] = '{4'h3, 4'h2, 4'h4, 4'h5, 4'h1, 4'hF, 4'h0, 4'h0};
	input_capture_channel DUT (.clk(clk), .rst_n(rst_n), .capture_channel(pin), .cpu_idle(idle),
		.cpu_sleep(sleep), .peripheral_clock(pc), .timer1_clock(t1), .timer2_clock(t2), .timer3_clock(t3),
		.timer4_clock(t4), .timer5_clock(t5), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_q(irq));
	capture_source_model src (.clk(clk), .rst_n(rst_n), .pin(pin), .peripheral_clock(pc),
		.timer1_clock(t1), .timer2_clock(t2), .timer3_clock(t3), .timer4_clock(t4), .timer5_clock(t5));
	// The 20 MHz clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Address and data go out together; each is dropped once taken.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		r = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// Pops stamps while the not-empty flag reads one, keeping the first two.
	task automatic drain;
		cnt = 0;
		rd(4'h0);
		while (r[3] === 1'b1 && cnt < 8) begin
			rd(4'h4);
			if (cnt == 0) v0 = r[15:0];
			if (cnt == 1) v1 = r[15:0];
			cnt++;
			rd(4'h0);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// The whole run needs well under ten thousand cycles.
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		wrap_up;
	end
	initial begin
		{rst_n, idle, sleep, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
		{awaddr, araddr, wdata} = 40'h0;
		wstrb = 4'h0;
		st = 4'hF;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(4'h0);
		chk(r, 32'h0);
		chk(resp, 2'h0);
		wr(4'h0, 32'hFFFFFFFF);
		rd(4'h0);
		chk(r, 32'h00003C67);
		// Only the low lane is written, so the high lane keeps its bits.
		st = 4'h1;
		wr(4'h0, 32'h0);
		st = 4'hF;
		rd(4'h0);
		chk(r, 32'h00003C00);
		wr(4'h4, 32'h1);
		chk(resp, 2'h2);
		wr(4'hD, 32'h1);
		chk(resp, 2'h2);
		rd(4'h2);
		chk(r, 32'h0);
		chk(resp, 2'h2);
		$display("test registers done");
		for (i = 0; i < 7; i++) begin
			wr(4'h0, 32'h0);
			wr(4'h0, 32'h0400 | i);
			src.pulses(np[i]);
			drain;
			chk(cnt, nc[i]);
			if (nc[i] > 1) chk({20'h0, v1[11:0] - v0[11:0]}, sp[i]);
		end
		$display("test modes done");
		wr(4'h0, 32'h0);
		wr(4'h0, 32'h0403);
		src.pulses(5);
		rd(4'h0);
		chk(r[4:3], 2'h3);
		// Earlier captures left the count event set; the overflow onset joins it now.
		rd(4'h8);
		chk(r, 32'h3);
		drain;
		chk(cnt, 4);
		chk(r[4:3], 2'h0);
		$display("test overflow done");
		wr(4'hC, 32'h1);
		for (i = 0; i < 4; i++) begin
			wr(4'h0, 32'h0);
			wr(4'h8, 32'h7);
			wr(4'h0, 32'h0403 | (i << 5));
			src.pulses(i);
			chk(irq, 1'b0);
			src.pulses(1);
			chk(irq, 1'b1);
		end
		wr(4'h0, 32'h0);
		wr(4'h8, 32'h7);
		wr(4'h0, 32'h0461);
		src.pulses(1);
		chk(irq, 1'b1);
		wr(4'hC, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		$display("test interrupt count done");
		wr(4'h0, 32'h0);
		wr(4'h0, 32'h2403);
		idle <= 1'b1;
		src.pulses(1);
		rd(4'h0);
		chk(r[3], 1'b0);
		wr(4'h0, 32'h0403);
		src.pulses(1);
		rd(4'h0);
		chk(r[3], 1'b1);
		idle <= 1'b0;
		$display("test idle done");
		wr(4'h0, 32'h0);
		wr(4'h8, 32'h7);
		wr(4'hC, 32'h4);
		wr(4'h0, 32'h0467);
		src.pulses(1);
		chk(irq, 1'b0);
		sleep <= 1'b1;
		src.pulses(1);
		chk(irq, 1'b1);
		rd(4'h8);
		chk(r, 32'h4);
		rd(4'h0);
		chk(r[3], 1'b0);
		sleep <= 1'b0;
		wr(4'h8, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		$display("test wake done");
		for (i = 0; i < 8; i++) begin
			wr(4'h0, 32'h0);
			wr(4'h0, {19'h0, tc[i], 10'h3});
			src.pulses(1);
			rd(4'h4);
			// The stamp less the live count leaves the base's offset, whose top nibble names it.
			dt = r[15:0] - src.cnt_q;
			if (i < 6) chk(dt[15:12], tn[i]);
			else chk(r[15:0], 16'h0000);
		end
		$display("test time base done");
		wrap_up;
	end
endmodule
`default_nettype wire
